// ### fbwp_defs.svh
`ifndef FBWP_DEFS_SVH
`define FBWP_DEFS_SVH

// Link command opcodes
`define FBWP_OP_WRITE_ENABLE_CMD        8'h06
`define FBWP_OP_WRDI        8'h04
`define FBWP_OP_STATUS_WR   8'h01
`define FBWP_OP_FUNC_WR     8'h42
`define FBWP_OP_PARAM_V     8'hc0
`define FBWP_OP_BANK_V      8'h17
`define FBWP_OP_CHIP_A      8'hc7
`define FBWP_OP_CHIP_B      8'h60
`define FBWP_OP_PP          8'h02
`define FBWP_OP_PP4         8'h12
`define FBWP_OP_SE_A        8'h20
`define FBWP_OP_SE_B        8'hd7
`define FBWP_OP_SE4         8'h21
`define FBWP_OP_BE32        8'h52
`define FBWP_OP_BE32_4      8'h5c
`define FBWP_OP_BE64        8'hd8
`define FBWP_OP_BE64_4      8'hdc
`define FBWP_OP_SUSPEND     8'h75
`define FBWP_OP_RESUME      8'h7a

// Frame lengths in link bits
`define FBWP_LEN_OPCODE     6'd8
`define FBWP_LEN_DATA       6'd16
`define FBWP_LEN_ADDR       6'd40

// Register byte offsets
`define FBWP_REG_STATUS     8'h00
`define FBWP_REG_FUNC       8'h04
`define FBWP_REG_CONFIG     8'h08
`define FBWP_REG_RESULT     8'h0c
`define FBWP_REG_VOLATILE   8'h10

// Status byte fields
`define FBWP_ST_WIP         0
`define FBWP_ST_WEL         1
`define FBWP_ST_BP_LO       2
`define FBWP_ST_QE          6
`define FBWP_ST_LOCK        7

// Function byte fields
`define FBWP_FN_RST_DIS     0
`define FBWP_FN_TBS         1
`define FBWP_FN_PROGRAM_PAUSED_FLAG        2
`define FBWP_FN_ERASE_PAUSED_FLAG        3
`define FBWP_FN_IRL_LO      4
`define FBWP_FN_RST_DIS_RST 1'b0

// Config and result fields
`define FBWP_CFG_BIG        0
`define FBWP_RES_APPLIED    8
`define FBWP_RES_REFUSED    9

// Array operation length in aclk cycles; long enough that a suspend frame
// sent right after the start can still arrive at link rates
`define FBWP_OP_CYCLES      8'd200

// AXI responses
`define FBWP_RESP_OKAY      2'b00
`define FBWP_RESP_SLVERR    2'b10

`endif

// ### fbwp_pkg.sv
package fbwp_pkg;

  typedef enum logic [1:0]
  {
    FBWP_IDLE = 2'b00,
    FBWP_BUSY = 2'b01,
    FBWP_SUSP = 2'b10
  } fbwp_state_t;

  typedef enum logic [1:0]
  {
    FBWP_KIND_NONE  = 2'b00,
    FBWP_KIND_PROG  = 2'b01,
    FBWP_KIND_ERASE = 2'b10,
    FBWP_KIND_CHIP  = 2'b11
  } fbwp_op_kind_t;

endpackage : fbwp_pkg

// ### fbwp_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fbwp_cmd_if;
  logic        toggle;
  logic [7:0]  opcode;
  logic [31:0] addr;
  logic [7:0]  data;

  modport rx
  (
    output toggle,
    output opcode,
    output addr,
    output data
  );

  modport core
  (
    input toggle,
    input opcode,
    input addr,
    input data
  );
endinterface : fbwp_cmd_if

`default_nettype wire

// ### fbwp_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbwp_defs.svh"

module fbwp_link_rx
  import fbwp_pkg::*;
(
  // Link pins
  input  wire logic sck,
  input  wire logic ce_n,
  input  wire logic si,
  // Reset from the register side
  input  wire logic aresetn,
  // Decoded command
  fbwp_cmd_if.rx    cmd
);

  logic [5:0]  cnt;
  logic [39:0] sr;
  logic [7:0]  op_cur;
  logic [39:0] next_sr;
  logic [7:0]  cur_op;
  logic [5:0]  need;
  logic        fire;

  always_comb
  begin
    next_sr = {sr[38:0], si};
    cur_op  = (cnt == 6'd7) ? next_sr[7:0] : op_cur;
    case (cur_op)
      `FBWP_OP_PP, `FBWP_OP_PP4, `FBWP_OP_SE_A, `FBWP_OP_SE_B, `FBWP_OP_SE4,
      `FBWP_OP_BE32, `FBWP_OP_BE32_4, `FBWP_OP_BE64, `FBWP_OP_BE64_4:
        need = `FBWP_LEN_ADDR;
      `FBWP_OP_STATUS_WR, `FBWP_OP_FUNC_WR, `FBWP_OP_PARAM_V, `FBWP_OP_BANK_V:
        need = `FBWP_LEN_DATA;
      default:
        need = `FBWP_LEN_OPCODE;
    endcase
    fire = (cnt >= 6'd7) && (cnt == need - 6'd1);
  end

  // The clock stops between frames, so the frame select ends the frame
  always_ff @(posedge sck or posedge ce_n)
  begin
    if (ce_n)
    begin
      cnt    <= 6'd0;
      sr     <= 40'h0;
      op_cur <= 8'h00;
    end
    else
    begin
      sr <= next_sr;
      if (cnt != 6'h3f)
        cnt <= cnt + 6'd1;
      if (cnt == 6'd7)
        op_cur <= next_sr[7:0];
    end
  end

  // Fields stay put until the next command so the core can read them after the toggle
  always_ff @(posedge sck or negedge aresetn)
  begin
    if (!aresetn)
    begin
      cmd.toggle <= 1'b0;
      cmd.opcode <= 8'h00;
      cmd.addr   <= 32'h0;
      cmd.data   <= 8'h00;
    end
    else if (fire)
    begin
      cmd.toggle <= ~cmd.toggle;
      cmd.opcode <= cur_op;
      cmd.addr   <= (need == `FBWP_LEN_ADDR) ? next_sr[31:0] : 32'h0;
      cmd.data   <= (need == `FBWP_LEN_DATA) ? next_sr[7:0] : 8'h00;
    end
  end

endmodule : fbwp_link_rx

`default_nettype wire

// ### fbwp_range.sv
`timescale 1ns/1ps
`default_nettype none

module fbwp_range
  import fbwp_pkg::*;
(
  // Protection setting
  input  wire logic [3:0]  code,
  input  wire logic        from_bottom,
  input  wire logic        big_blocks,
  // Target
  input  wire logic [25:0] addr,
  // Result
  output logic             hit
);

  logic [10:0] count;
  logic [10:0] total;
  logic [10:0] idx;

  always_comb
  begin
    count = 11'd0;
    if (big_blocks)
    begin
      if (code >= 4'd9)
        count = 11'd256;
      else if (code != 4'd0)
        count = 11'd1 << (code - 4'd1);
    end
    else
    begin
      case (code)
        4'd0:    count = 11'd0;
        4'd11:   count = 11'd768;
        4'd12:   count = 11'd896;
        4'd13:   count = 11'd960;
        4'd14:   count = 11'd992;
        4'd15:   count = 11'd1024;
        default: count = 11'd1 << (code - 4'd1);
      endcase
    end
    total = big_blocks ? 11'd256 : 11'd1024;
    idx   = big_blocks ? {3'b000, addr[25:18]} : {1'b0, addr[25:16]};
    if (from_bottom)
      hit = idx < count;
    else
      hit = idx >= (total - count);
  end

endmodule : fbwp_range

`default_nettype wire

// ### fbwp_top.sv
// Behaviour
// - Volatile read-parameter and bank writes are accepted without write enable.
// - Program or erase into the protected range is inhibited.
// - Whole-array erase is ignored unless the protection code is zero.
// - Locked status with protect pin low and quad enable low makes status bits read-only, writes ignored.
// - Status writes apply when unlocked, or locked with protect pin high or quad enable high.
// - Quad enable low: upper pins are protect and hold/reset; high: data lines.
// - 64KB blocks: code 0 none, codes 1-10 protect 1 doubling to 512.
// - 64KB blocks: codes 11-15 protect 768, 896, 960, 992, 1024 blocks.
// - Bottom select places the protected range from block 0 upward.
// - 256KB variant: codes 1-8 protect 1 to 128; 9 and up all.
// - Function byte holds row locks, suspend flags, bottom select, reset disable.
// - Bottom select is one-time: once set it never returns to zero.
// - Program-paused flag sets on suspend during program, clears on resume.
`timescale 1ns/1ps
`default_nettype none
`include "fbwp_defs.svh"

module fbwp_top
  import fbwp_pkg::*;
(
  // System
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial link
  input  wire logic        sck,
  input  wire logic        ce_n,
  input  wire logic        si,
  input  wire logic        wp_io2,
  input  wire logic        hold_io3,
  // Array and pin functions
  output logic             op_start,
  output fbwp_op_kind_t    op_kind,
  output logic [25:0]      op_addr,
  output logic             hold_active,
  output logic             pin_reset,
  output logic             quad_mode
);

  fbwp_cmd_if cmd ();

  fbwp_link_rx u_rx
  (
    .sck     (sck),
    .ce_n    (ce_n),
    .si      (si),
    .aresetn (aresetn),
    .cmd     (cmd.rx)
  );

  // Crossing: toggle plus stable fields, pins as levels
  logic       tog_s1, tog_s2, tog_s3;
  logic       wp_s1, wp_s2;
  logic       hold_s1, hold_s2;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tog_s1  <= 1'b0;
      tog_s2  <= 1'b0;
      tog_s3  <= 1'b0;
      wp_s1   <= 1'b1;
      wp_s2   <= 1'b1;
      hold_s1 <= 1'b1;
      hold_s2 <= 1'b1;
    end
    else
    begin
      tog_s1  <= cmd.toggle;
      tog_s2  <= tog_s1;
      tog_s3  <= tog_s2;
      wp_s1   <= wp_io2;
      wp_s2   <= wp_s1;
      hold_s1 <= hold_io3;
      hold_s2 <= hold_s1;
    end
  end

  logic        evt;
  logic [7:0]  cmd_op;
  logic [25:0] cmd_addr;
  logic [7:0]  cmd_data;

  assign evt      = tog_s2 ^ tog_s3;
  assign cmd_op   = cmd.opcode;
  assign cmd_addr = cmd.addr[25:0];
  assign cmd_data = cmd.data;

  // Protection and function state
  logic          wel;
  logic [3:0]    bp;
  logic          qe;
  logic          lock;
  logic [3:0]    irl;
  logic          erase_paused_flag, program_paused_flag, protect_from_bottom, rst_dis;
  logic [7:0]    read_param;
  logic [7:0]    bank;
  logic          big;
  logic [7:0]    last_op;
  logic          applied, refused;
  fbwp_state_t   state;
  fbwp_op_kind_t run_kind;
  logic [7:0]    timer;
  logic          prot_hit;
  logic          wp_eff;
  logic          lock_ok;

  fbwp_range u_range
  (
    .code        (bp),
    .from_bottom (protect_from_bottom),
    .big_blocks  (big),
    .addr        (cmd_addr),
    .hit         (prot_hit)
  );

  // In quad mode the protect pin is a data line and no longer guards the status
  assign wp_eff  = qe ? 1'b1 : wp_s2;
  assign lock_ok = !lock || wp_eff;

  logic          do_write_enable_cmd, do_wrdi, do_status, do_func, do_param, do_bank;
  logic          do_start, do_susp, do_resume, do_refuse;
  fbwp_op_kind_t start_kind;
  fbwp_op_kind_t cmd_kind;

  always_comb
  begin
    case (cmd_op)
      `FBWP_OP_PP, `FBWP_OP_PP4:
        cmd_kind = FBWP_KIND_PROG;
      `FBWP_OP_SE_A, `FBWP_OP_SE_B, `FBWP_OP_SE4, `FBWP_OP_BE32, `FBWP_OP_BE32_4,
      `FBWP_OP_BE64, `FBWP_OP_BE64_4:
        cmd_kind = FBWP_KIND_ERASE;
      `FBWP_OP_CHIP_A, `FBWP_OP_CHIP_B:
        cmd_kind = FBWP_KIND_CHIP;
      default:
        cmd_kind = FBWP_KIND_NONE;
    endcase
  end

  always_comb
  begin
    do_write_enable_cmd    = 1'b0;
    do_wrdi    = 1'b0;
    do_status  = 1'b0;
    do_func    = 1'b0;
    do_param   = 1'b0;
    do_bank    = 1'b0;
    do_start   = 1'b0;
    do_susp    = 1'b0;
    do_resume  = 1'b0;
    do_refuse  = 1'b0;
    start_kind = FBWP_KIND_NONE;
    if (evt)
    begin
      case (state)
        FBWP_IDLE:
        begin
          if (cmd_op == `FBWP_OP_WRITE_ENABLE_CMD)
            do_write_enable_cmd = 1'b1;
          else if (cmd_op == `FBWP_OP_WRDI)
            do_wrdi = 1'b1;
          else if (cmd_op == `FBWP_OP_STATUS_WR)
          begin
            do_status = wel && lock_ok;
            do_refuse = !(wel && lock_ok);
          end
          else if (cmd_op == `FBWP_OP_FUNC_WR)
          begin
            do_func   = wel;
            do_refuse = !wel;
          end
          else if (cmd_op == `FBWP_OP_PARAM_V)
            do_param = 1'b1;
          else if (cmd_op == `FBWP_OP_BANK_V)
            do_bank = 1'b1;
          else if (cmd_kind == FBWP_KIND_CHIP)
          begin
            do_start   = wel && (bp == 4'h0);
            do_refuse  = !(wel && (bp == 4'h0));
            start_kind = cmd_kind;
          end
          else if (cmd_kind != FBWP_KIND_NONE)
          begin
            do_start   = wel && !prot_hit;
            do_refuse  = !(wel && !prot_hit);
            start_kind = cmd_kind;
          end
        end
        FBWP_BUSY:
          do_susp = (cmd_op == `FBWP_OP_SUSPEND) && (run_kind != FBWP_KIND_CHIP);
        FBWP_SUSP:
          do_resume = (cmd_op == `FBWP_OP_RESUME);
        default:
          do_refuse = 1'b0;
      endcase
    end
  end

  // Operation sequencer; commands other than suspend/resume are dropped while busy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state    <= FBWP_IDLE;
      run_kind <= FBWP_KIND_NONE;
      timer    <= 8'h00;
    end
    else
    begin
      case (state)
        FBWP_IDLE:
          if (do_start)
          begin
            state    <= FBWP_BUSY;
            run_kind <= start_kind;
            timer    <= `FBWP_OP_CYCLES;
          end
        FBWP_BUSY:
          if (do_susp)
            state <= FBWP_SUSP;
          else if (timer == 8'h01)
          begin
            state    <= FBWP_IDLE;
            run_kind <= FBWP_KIND_NONE;
            timer    <= 8'h00;
          end
          else
            timer <= timer - 8'h01;
        FBWP_SUSP:
          if (do_resume)
            state <= FBWP_BUSY;
        default:
          state <= FBWP_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wel <= 1'b0;
    else if (do_write_enable_cmd)
      wel <= 1'b1;
    else if (do_wrdi || do_status || do_func)
      wel <= 1'b0;
    else if (state == FBWP_BUSY && timer == 8'h01 && !do_susp)
      wel <= 1'b0;
  end

  // These bits stand in for nonvolatile cells, cleared by reset here and loaded from the data byte by a permitted status write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock <= 1'b0;
      qe   <= 1'b0;
      bp   <= 4'h0;
    end
    else if (do_status)
    begin
      lock <= cmd_data[`FBWP_ST_LOCK];
      qe   <= cmd_data[`FBWP_ST_QE];
      bp   <= cmd_data[`FBWP_ST_BP_LO +: 4];
    end
  end

  // One-time bits only ever accumulate ones
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irl     <= 4'h0;
      protect_from_bottom     <= 1'b0;
      rst_dis <= `FBWP_FN_RST_DIS_RST;
    end
    else if (do_func)
    begin
      irl     <= irl | cmd_data[`FBWP_FN_IRL_LO +: 4];
      protect_from_bottom     <= protect_from_bottom | cmd_data[`FBWP_FN_TBS];
      rst_dis <= rst_dis | cmd_data[`FBWP_FN_RST_DIS];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      program_paused_flag <= 1'b0;
      erase_paused_flag <= 1'b0;
    end
    else if (do_susp)
    begin
      program_paused_flag <= (run_kind == FBWP_KIND_PROG);
      erase_paused_flag <= (run_kind == FBWP_KIND_ERASE);
    end
    else if (do_resume)
    begin
      program_paused_flag <= 1'b0;
      erase_paused_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      read_param <= 8'h00;
      bank       <= 8'h00;
    end
    else
    begin
      if (do_param)
        read_param <= cmd_data;
      if (do_bank)
        bank <= cmd_data;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_op <= 8'h00;
      applied <= 1'b0;
      refused <= 1'b0;
    end
    else if (evt)
    begin
      last_op <= cmd_op;
      applied <= do_write_enable_cmd | do_wrdi | do_status | do_func | do_param | do_bank |
                 do_start | do_susp | do_resume;
      refused <= do_refuse;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_start    <= 1'b0;
      op_kind     <= FBWP_KIND_NONE;
      op_addr     <= 26'h0;
      hold_active <= 1'b0;
      pin_reset   <= 1'b0;
      quad_mode   <= 1'b0;
    end
    else
    begin
      op_start <= do_start;
      if (do_start)
      begin
        op_kind <= start_kind;
        op_addr <= (start_kind == FBWP_KIND_CHIP) ? 26'h0 : cmd_addr;
      end
      hold_active <= !qe && !hold_s2 && !read_param[7];
      pin_reset   <= !qe && !hold_s2 && read_param[7];
      quad_mode   <= qe;
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  logic       aw_have, w_have;
  logic [7:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic       wstrb0_q;
  logic       aw_hs, w_hs, ar_hs;

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      awaddr_q      <= 8'h00;
      wbyte_q       <= 8'h00;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FBWP_RESP_OKAY;
      big           <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_hs && !aw_have && !s_axi_bvalid;
      s_axi_wready  <= !w_hs && !w_have && !s_axi_bvalid;
      if (aw_hs)
      begin
        aw_have  <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_have   <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (aw_have && w_have && !s_axi_bvalid)
      begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `FBWP_RESP_OKAY;
        if (awaddr_q == `FBWP_REG_CONFIG)
        begin
          if (wstrb0_q)
            big <= wbyte_q[`FBWP_CFG_BIG];
        end
        else if (awaddr_q == `FBWP_REG_STATUS || awaddr_q == `FBWP_REG_FUNC ||
                 awaddr_q == `FBWP_REG_RESULT || awaddr_q == `FBWP_REG_VOLATILE)
          s_axi_bresp <= `FBWP_RESP_OKAY;
        else
          s_axi_bresp <= `FBWP_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  logic [31:0] rd_data;
  logic        rd_err;

  always_comb
  begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (s_axi_araddr == `FBWP_REG_STATUS)
      rd_data = {24'h0, lock, qe, bp, wel, state != FBWP_IDLE};
    else if (s_axi_araddr == `FBWP_REG_FUNC)
      rd_data = {24'h0, irl, erase_paused_flag, program_paused_flag, protect_from_bottom, rst_dis};
    else if (s_axi_araddr == `FBWP_REG_CONFIG)
      rd_data = {31'h0, big};
    else if (s_axi_araddr == `FBWP_REG_RESULT)
      rd_data = {22'h0, refused, applied, last_op};
    else if (s_axi_araddr == `FBWP_REG_VOLATILE)
      rd_data = {16'h0, bank, read_param};
    else
      rd_err = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `FBWP_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !ar_hs && !s_axi_rvalid;
      if (ar_hs)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_err ? `FBWP_RESP_SLVERR : `FBWP_RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chip_erase_gate_a: assert property (op_start && op_kind == FBWP_KIND_CHIP |-> $past(bp) == 4'h0)
    else $error("chip erase started with protection set");
  prot_block_a: assert property (op_start && op_kind != FBWP_KIND_CHIP |-> !$past(prot_hit))
    else $error("array operation started inside protected range");
  lock_ro_a: assert property (lock && !wp_eff |=> $stable({lock, qe, bp}))
    else $error("locked status bits changed");
  status_apply_a: assert property (evt && state == FBWP_IDLE && cmd_op == `FBWP_OP_STATUS_WR && wel && lock_ok |=> {lock, qe, bp} == $past(cmd_data[7:2]) && !wel)
    else $error("permitted status write not applied");
  param_vol_a: assert property (evt && state == FBWP_IDLE && cmd_op == `FBWP_OP_PARAM_V |=> read_param == $past(cmd_data) && applied)
    else $error("volatile parameter write not applied");
  tbs_otp_a: assert property (protect_from_bottom |=> protect_from_bottom)
    else $error("bottom select returned to zero");
  program_paused_flag_set_a: assert property (do_susp && run_kind == FBWP_KIND_PROG |=> program_paused_flag && state == FBWP_SUSP ##1 program_paused_flag)
    else $error("program paused flag not set on suspend");
  quad_pins_a: assert property (qe |=> quad_mode && !hold_active && !pin_reset)
    else $error("upper pins not released to data use");
  range_top_a: assert property (!big && !protect_from_bottom && bp == 4'h1 |-> prot_hit == (cmd_addr[25:16] == 10'h3ff))
    else $error("single top block range wrong");
  range_bottom_a: assert property (!big && protect_from_bottom && bp == 4'hb |-> prot_hit == (cmd_addr[25:16] < 10'd768))
    else $error("bottom 768 block range wrong");
  big_all_a: assert property (big && bp[3] && bp[2:0] != 3'h0 |-> prot_hit)
    else $error("large block variant not fully protected");

  chip_erase_c: cover property (op_start && op_kind == FBWP_KIND_CHIP);
  suspend_c: cover property (state == FBWP_BUSY ##1 state == FBWP_SUSP ##[1:200] state == FBWP_BUSY);
  refused_status_c: cover property (evt && cmd_op == `FBWP_OP_STATUS_WR && wel && !lock_ok);

endmodule : fbwp_top

`default_nettype wire

// ### fbwp_link_host.sv
`timescale 1ns/1ps
`default_nettype none
module fbwp_link_host
(
  // Link pins
  output logic sck,
  output logic ce_n,
  output logic si
);
  initial
  begin
    sck = 1'b0;
    ce_n = 1'b1;
    si = 1'b0;
  end
  // Clock stands still between frames; data flips so a stale bit cannot pass
  task automatic frame(input logic [39:0] bits, input int n);
    ce_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      si = bits[39-i];
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    ce_n = 1'b1;
    si = ~si;
    #100;
  endtask : frame
endmodule : fbwp_link_host
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbwp_defs.svh"
module testbench;
  import fbwp_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, wp_io2 = 1'b1, hold_io3 = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, code;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic op_start, hold_active, pin_reset, quad_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [25:0] op_addr, last_addr, a;
  fbwp_op_kind_t op_kind, last_kind;
  wire sck, ce_n, si;
  int n_fail = 0, comparisons = 0, starts = 0;
  integer seed = 32'hc9b96b08;

  fbwp_top dut (.*);
  fbwp_link_host host (.sck(sck), .ce_n(ce_n), .si(si));

  always #5 aclk = ~aclk;
  always @(posedge aclk)
    if (op_start === 1'b1)
    begin
      starts++;
      last_addr = op_addr;
      last_kind = op_kind;
    end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axw(input logic [7:0] ad, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask : axw

  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_arvalid || s_axi_rready);
    check(d & m, e);
  endtask : rd

  task automatic stw(input logic [7:0] v);
    host.frame({8'h06, 32'h0}, 8);
    host.frame({8'h01, v, 24'h0}, 16);
  endtask : stw

  task automatic prog(input logic [7:0] op, input logic [25:0] ad, input logic e,
                      input fbwp_op_kind_t k);
    int s0;
    s0 = starts;
    host.frame({8'h06, 32'h0}, 8);
    host.frame({op, 6'h0, ad}, (op == 8'hc7) ? 8 : 40);
    repeat (220) @(posedge aclk);
    check(starts - s0, e);
    if (e)
    begin
      check(last_kind, k);
      check(last_addr, ad);
    end
  endtask : prog

  function automatic logic hit(input logic [3:0] c, input logic bot, input logic big,
                               input logic [25:0] ad);
    int cnt, tot, blk;
    tot = big ? 256 : 1024;
    blk = big ? ad[25:18] : ad[25:16];
    cnt = (c == 0) ? 0 : big ? ((c > 8) ? 256 : 1 << (c - 1)) : (c == 15) ? 1024 :
          (c > 10) ? 1024 - (256 >> (c - 11)) : 1 << (c - 1);
    return bot ? (blk < cnt) : (blk >= tot - cnt);
  endfunction : hit

  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #600000;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(8'h00, 32'hff, 32'h0);
    rd(8'h04, 32'hff, 32'h0);
    rd(8'h40, 32'h0, 32'h0);
    check(r, `FBWP_RESP_SLVERR);
    axw(8'h40, 32'h0);
    check(r, `FBWP_RESP_SLVERR);
    host.frame({8'hc0, 8'ha5, 24'h0}, 16);
    host.frame({8'h17, 8'h3c, 24'h0}, 16);
    rd(8'h10, 32'hffff, 32'h3ca5);
    @(posedge aclk);
    wp_io2 <= 1'b0;
    stw(8'h8c);
    rd(8'h00, 32'hfc, 32'h8c);
    stw(8'h00);
    rd(8'h00, 32'hfc, 32'h8c);
    prog(8'hc7, 26'h0, 1'b0, FBWP_KIND_CHIP);
    rd(8'h0c, 32'h3ff, 32'h2c7);
    @(posedge aclk);
    wp_io2 <= 1'b1;
    stw(8'h40);
    rd(8'h00, 32'hfc, 32'h40);
    check(quad_mode, 1'b1);
    @(posedge aclk);
    hold_io3 <= 1'b0;
    repeat (4) @(posedge aclk);
    check(hold_active, 1'b0);
    check(pin_reset, 1'b0);
    stw(8'h00);
    check(quad_mode, 1'b0);
    check(pin_reset, 1'b1);
    host.frame({8'hc0, 8'h25, 24'h0}, 16);
    check(hold_active, 1'b1);
    prog(8'hc7, 26'h0, 1'b1, FBWP_KIND_CHIP);
    host.frame({8'h06, 32'h0}, 8);
    host.frame({8'h02, 32'h0}, 40);
    host.frame({8'h75, 32'h0}, 8);
    rd(8'h04, 32'h0c, 32'h04);
    host.frame({8'h7a, 32'h0}, 8);
    rd(8'h04, 32'h0c, 32'h00);
    repeat (220) @(posedge aclk);
    host.frame({8'h06, 32'h0}, 8);
    host.frame({8'h04, 32'h0}, 8);
    rd(8'h00, 32'h02, 32'h00);
    for (int ph = 0; ph < 3; ph++)
    begin
      if (ph == 1)
      begin
        stw(8'h00);
        host.frame({8'h06, 32'h0}, 8);
        host.frame({8'h42, 8'h02, 24'h0}, 16);
        host.frame({8'h06, 32'h0}, 8);
        host.frame({8'h42, 8'h00, 24'h0}, 16);
        rd(8'h04, 32'hff, 32'h02);
      end
      if (ph == 2)
      begin
        axw(8'h08, 32'h1);
        check(r, `FBWP_RESP_OKAY);
        rd(8'h08, 32'h1, 32'h1);
      end
      for (int i = 0; i < 8; i++)
      begin
        code = (i == 0) ? 4'h1 : 4'($random(seed));
        a = (i == 0) ? {26{ph == 0}} : 26'($random(seed));
        stw({2'b00, code, 2'b00});
        prog((i % 2) ? 8'h20 : 8'h02, a, !hit(code, ph > 0, ph == 2, a),
             (i % 2) ? FBWP_KIND_ERASE : FBWP_KIND_PROG);
      end
    end
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
